// [core/usbxc_consts.vh]
// constants for the usb transceiver control block
// assumes inclusion by bare name from core/ files
`ifndef USBXC_CONSTS_VH
`define USBXC_CONSTS_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define USBXC_CTRL_ADDR     8'hd7
`define USBXC_CTRL_RESET    8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define USBXC_PULLUP_EN_BIT 7
`define USBXC_XCVR_EN_BIT   6
`define USBXC_SPEED_BIT     5
`define USBXC_TST_HI        4
`define USBXC_TST_LO        3
`define USBXC_DIFF_BIT      2
`define USBXC_POS_LVL_BIT   1
`define USBXC_NEG_LVL_BIT   0

// ----------------------------------------
// line test modes
// ----------------------------------------
`define USBXC_TST_NORMAL    2'b00
`define USBXC_TST_DIFF1     2'b01
`define USBXC_TST_DIFF0     2'b10
`define USBXC_TST_SE0       2'b11

// ----------------------------------------
// endpoint protocol addresses
// ----------------------------------------
`define USBXC_EP0_ADDR      8'h00
`define USBXC_EP_IN_FLAG    8'h80
`define USBXC_EP_MAX        2'd3

`endif

// [core/usbxc_line_sync.v]
// two-flop synchroniser for the bus line levels and vbus
// assumes inputs asynchronous to clk
module usbxc_line_sync (
  clk,
  rst_n,
  async_in,
  sync_out
);
  input  wire       clk;
  input  wire       rst_n;
  input  wire [2:0] async_in;
  output wire [2:0] sync_out;

  reg [2:0] meta_r;
  reg [2:0] sync_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule

// [core/usbxc_top.v]
// transceiver control register and endpoint address decode of a usb function
// assumes an 8-bit special register bus on clk; line and vbus pins are async
`include "usbxc_consts.vh"

module usbxc_top (
  clk,
  rst_n,
  reg_addr,
  reg_wr,
  reg_rd,
  reg_wdata,
  reg_rdata,
  reg_hit,
  dp_in,
  dn_in,
  vbus_in,
  dp_out,
  dp_oe,
  dn_out,
  dn_oe,
  pullup_dp,
  pullup_dn,
  full_speed,
  transceiver_suspend,
  tx_dp,
  tx_dn,
  tx_drive,
  tok_ep_addr,
  tok_ep_valid,
  tok_ep_num,
  tok_ep_in
);
  input  wire       clk;
  input  wire       rst_n;
  input  wire [7:0] reg_addr;
  input  wire       reg_wr;
  input  wire       reg_rd;
  input  wire [7:0] reg_wdata;
  output reg  [7:0] reg_rdata;
  output wire       reg_hit;
  input  wire       dp_in;
  input  wire       dn_in;
  input  wire       vbus_in;
  output reg        dp_out;
  output reg        dp_oe;
  output reg        dn_out;
  output reg        dn_oe;
  output reg        pullup_dp;
  output reg        pullup_dn;
  output reg        full_speed;
  output reg        transceiver_suspend;
  input  wire       tx_dp;
  input  wire       tx_dn;
  input  wire       tx_drive;
  input  wire [7:0] tok_ep_addr;
  output reg        tok_ep_valid;
  output reg  [1:0] tok_ep_num;
  output reg        tok_ep_in;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // endpoint address to pipe; only 0x00, 0x01-0x03 and 0x81-0x83 are valid
  function ep_valid;
    input [7:0] a;
    begin
      ep_valid = (a == `USBXC_EP0_ADDR) ||
                 ((a[6:2] == 5'h00) && (a[1:0] != 2'd0) &&
                  (a[1:0] <= `USBXC_EP_MAX));
    end
  endfunction

  // ----------------------------------------
  // input synchronisation
  // ----------------------------------------
  wire [2:0] sync_w;
  wire       dp_s;
  wire       dn_s;
  wire       vbus_s;

  usbxc_line_sync u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({vbus_in, dp_in, dn_in}),
    .sync_out (sync_w)
  );

  assign vbus_s = sync_w[2];
  assign dp_s   = sync_w[1];
  assign dn_s   = sync_w[0];

  // ----------------------------------------
  // control register
  // ----------------------------------------
  reg        pullup_enable_r;
  reg        transceiver_enable_r;
  reg        speed_r;
  reg  [1:0] line_test_mode_r;
  reg        diff_receiver_level_r;
  wire       wr_hit;

  assign reg_hit = (reg_addr == `USBXC_CTRL_ADDR);
  assign wr_hit  = reg_wr && reg_hit;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pullup_enable_r      <= 1'b0;
      transceiver_enable_r <= 1'b0;
      speed_r              <= 1'b0;
      line_test_mode_r     <= `USBXC_TST_NORMAL;
    end else if (wr_hit) begin
      pullup_enable_r      <= reg_wdata[`USBXC_PULLUP_EN_BIT];
      transceiver_enable_r <= reg_wdata[`USBXC_XCVR_EN_BIT];
      speed_r              <= reg_wdata[`USBXC_SPEED_BIT];
      line_test_mode_r     <= reg_wdata[`USBXC_TST_HI:`USBXC_TST_LO];
    end
  end

  // receiver holds its last value while suspended
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      diff_receiver_level_r <= 1'b0;
    end else if (transceiver_enable_r) begin
      diff_receiver_level_r <= dp_s & ~dn_s;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `USBXC_CTRL_RESET;
    end else if (reg_rd && reg_hit) begin
      reg_rdata <= {pullup_enable_r, transceiver_enable_r, speed_r, line_test_mode_r,
                    diff_receiver_level_r,
                    dp_s,
                    dn_s};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // pull-up, speed and line drive
  // ----------------------------------------
  // no host mode exists: no downstream pull-downs, no reset or sof generation
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pullup_dp           <= 1'b0;
      pullup_dn           <= 1'b0;
      full_speed          <= 1'b0;
      transceiver_suspend <= 1'b1;
      dp_out              <= 1'b0;
      dp_oe               <= 1'b0;
      dn_out              <= 1'b0;
      dn_oe               <= 1'b0;
    end else begin
      pullup_dp           <= pullup_enable_r && vbus_s && speed_r;
      pullup_dn           <= pullup_enable_r && vbus_s && !speed_r;
      full_speed          <= speed_r;
      transceiver_suspend <= !transceiver_enable_r;
      case (line_test_mode_r)
        `USBXC_TST_DIFF1: begin
          dp_out <= 1'b1;
          dn_out <= 1'b0;
          dp_oe  <= 1'b1;
          dn_oe  <= 1'b1;
        end
        `USBXC_TST_DIFF0: begin
          dp_out <= 1'b0;
          dn_out <= 1'b1;
          dp_oe  <= 1'b1;
          dn_oe  <= 1'b1;
        end
        `USBXC_TST_SE0: begin
          dp_out <= 1'b0;
          dn_out <= 1'b0;
          dp_oe  <= 1'b1;
          dn_oe  <= 1'b1;
        end
        default: begin
          dp_out <= tx_dp;
          dn_out <= tx_dn;
          dp_oe  <= tx_drive && transceiver_enable_r;
          dn_oe  <= tx_drive && transceiver_enable_r;
        end
      endcase
    end
  end

  // ----------------------------------------
  // endpoint decode
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tok_ep_valid <= 1'b0;
      tok_ep_num   <= 2'd0;
      tok_ep_in    <= 1'b0;
    end else begin
      tok_ep_valid <= ep_valid(tok_ep_addr);
      tok_ep_num   <= tok_ep_addr[1:0];
      // endpoint 0 is bidirectional, direction flag meaningless there
      tok_ep_in    <= (tok_ep_addr & `USBXC_EP_IN_FLAG) != 8'h00;
    end
  end
endmodule

// [testbench/usbxc_host_model.sv]
// host end of the usb lines, with the usual pull-downs
// assumes the bench says when the host drives
module usbxc_host_model (
  input  logic dp_out,
  input  logic dp_oe,
  input  logic dn_out,
  input  logic dn_oe,
  input  logic pullup_dp,
  input  logic pullup_dn,
  input  logic host_en,
  input  logic host_j,
  output logic dp_in,
  output logic dn_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released line falls to the pull-up, else to the host pull-down
  assign dp_in = dp_oe ? dp_out : host_en ? host_j : pullup_dp;
  assign dn_in = dn_oe ? dn_out : host_en ? !host_j : pullup_dn;
endmodule

// [testbench/usbxc_top_asserts.sv]
// checker on the usbxc_top ports
// assumes the single clk domain; bound at the foot
module usbxc_chk (
  input logic       clk,
  input logic       rst_n,
  input logic       reg_wr,
  input logic       reg_hit,
  input logic [7:0] reg_wdata,
  input logic       vbus_in,
  input logic       dp_out,
  input logic       dp_oe,
  input logic       dn_out,
  input logic       dn_oe,
  input logic       pullup_dp,
  input logic       pullup_dn,
  input logic       full_speed,
  input logic       transceiver_suspend,
  input logic [7:0] tok_ep_addr,
  input logic       tok_ep_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic       w;
  logic       ok;
  logic [1:0] m;
  assign w = reg_wr && reg_hit;
  assign m = reg_wdata[4:3];
  assign ok = tok_ep_addr[6:2] == 0 && (tok_ep_addr[1:0] != 0 || !tok_ep_addr[7]);
  property p_fs; w |-> ##2 full_speed == $past(reg_wdata[5], 2); endproperty
  a_fs: assert property (p_fs) else $error("speed");
  property p_sus; w |-> ##2 transceiver_suspend != $past(reg_wdata[6], 2); endproperty
  a_sus: assert property (p_sus) else $error("suspend");
  property p_pdp; pullup_dp |-> full_speed && !pullup_dn; endproperty
  a_pdp: assert property (p_pdp) else $error("pullup dp");
  property p_pdn; pullup_dn |-> !full_speed; endproperty
  a_pdn: assert property (p_pdn) else $error("pullup dn");
  property p_det; w && !reg_wdata[7] |-> ##2 !(pullup_dp || pullup_dn); endproperty
  a_det: assert property (p_det) else $error("detach");
  property p_vb; !vbus_in [*4] |-> !(pullup_dp || pullup_dn); endproperty
  a_vb: assert property (p_vb) else $error("vbus");
  property p_tst; w && m != 0 |-> ##2 dp_oe && dn_oe && dp_out == ($past(m, 2) == 1)
    && dn_out == ($past(m, 2) == 2); endproperty
  a_tst: assert property (p_tst) else $error("test mode");
  property p_ep; $past(rst_n) |-> tok_ep_valid == $past(ok); endproperty
  a_ep: assert property (p_ep) else $error("endpoint");
endmodule
bind usbxc_top usbxc_chk u_chk (.clk, .rst_n, .reg_wr, .reg_hit, .reg_wdata, .vbus_in,
  .dp_out, .dp_oe, .dn_out, .dn_oe, .pullup_dp, .pullup_dn, .full_speed,
  .transceiver_suspend, .tok_ep_addr, .tok_ep_valid);

// [testbench/tb_usb_transceiver_control.sv]
// bench for usbxc_top: register, line and endpoint checks
// assumes usbxc_host_model on the lines
module tb_usb_transceiver_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst_n, reg_wr, reg_rd, reg_hit, vbus_in, dp_in, dn_in, host_en, host_j;
  logic       dp_out, dp_oe, dn_out, dn_oe, pullup_dp, pullup_dn, full_speed, tx_dp;
  logic       transceiver_suspend, tx_dn, tx_drive, tok_ep_valid, tok_ep_in;
  logic [1:0] tok_ep_num;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tok_ep_addr, v;
  logic [2:0] st [1:3] = '{3'b110, 3'b001, 3'b000};
  int         fails = 0;
  int         comparisons = 0;
  usbxc_top dut (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .reg_hit, .dp_in, .dn_in, .vbus_in, .dp_out, .dp_oe, .dn_out, .dn_oe, .pullup_dp,
    .pullup_dn, .full_speed, .transceiver_suspend, .tx_dp, .tx_dn, .tx_drive,
    .tok_ep_addr, .tok_ep_valid, .tok_ep_num, .tok_ep_in);
  usbxc_host_model host (.dp_out, .dp_oe, .dn_out, .dn_oe, .pullup_dp, .pullup_dn,
    .host_en, .host_j, .dp_in, .dn_in);
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clk) reg_wr = 0;
    repeat (5) @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clk) reg_rd = 0;
    chk(reg_rdata, exp);
  endtask
  // line values only count while driven
  task automatic pins(input logic [7:0] exp);
    chk({pullup_dp, pullup_dn, full_speed, transceiver_suspend, dp_oe, dn_oe,
         dp_oe & dp_out, dn_oe & dn_out}, exp);
  endtask
  initial begin
    {reg_wr, reg_rd, vbus_in, tx_dp, tx_dn, tx_drive, host_en, host_j, rst_n} = '0;
    {reg_addr, reg_wdata, tok_ep_addr} = '0;
    repeat (4) @(negedge clk);
    rst_n = 1;
    pins(8'h10);
    rd(8'hd7, 8'h00);
    vbus_in = 1;
    wr(8'hd7, 8'he7);
    pins(8'ha0);
    rd(8'hd7, 8'he6);
    wr(8'hd7, 8'hc0);
    pins(8'h40);
    rd(8'hd7, 8'hc1);
    host_en = 1;
    host_j = 1;
    repeat (4) @(negedge clk);
    rd(8'hd7, 8'hc6);
    host_en = 0;
    vbus_in = 0;
    repeat (8) @(negedge clk);
    pins(8'h00);
    rd(8'hd7, 8'hc0);
    $display("attach tests done");
    vbus_in = 1;
    wr(8'hd7, 8'h60);
    pins(8'h20);
    tx_drive = 1;
    tx_dp = 1;
    repeat (2) @(negedge clk);
    pins(8'h2e);
    tx_drive = 0;
    for (int m = 1; m < 4; m++) begin
      v = 8'h40 | 8'(m << 3);
      wr(8'hd7, v);
      pins({6'h03, st[m][1:0]});
      rd(8'hd7, v | {5'h00, st[m]});
    end
    rd(8'hd6, 8'h00);
    chk({7'h00, reg_hit}, 8'h00);
    wr(8'hd6, 8'hff);
    rd(8'hd7, 8'h58);
    chk({7'h00, reg_hit}, 8'h01);
    $display("line test modes done");
    for (int i = 0; i < 256; i++) begin
      v = i[7:0];
      tok_ep_addr = v;
      @(negedge clk);
      chk({4'h0, tok_ep_valid, tok_ep_num, tok_ep_in},
          {4'h0, v[6:2] == 0 && (v[1:0] != 0 || !v[7]), v[1:0], v[7]});
    end
    $display("endpoint tests done");
    tally_and_finish;
  end
  // the tests need some 330 cycles
  initial begin
    #20000;
    fails++;
    tally_and_finish;
  end
endmodule
